// [hdl/qspi_ctrl.sv]
// Behaviour
// - Data lanes selectable: one, two, four
// - Frame width 8, 16 or 32 bits
// - Length counted in bytes, ends data phase
// - Optional command byte before data, one select
// - Interrupts on transmit consumed and completion
// - DMA request when received word ready
// - Pollable completion and buffer status
// - Mapped mode for NOR or PSRAM, selectable
// - Mapped window answers SLVERR while mapped mode inactive
// - NOR reads 3B or BB, dual lanes
// - NOR reads 6B or EB, quad lanes
// - PSRAM reads 0B or EB, quad lanes
// - PSRAM writes use 02h or 38h
// - Window offset, low two bits cleared, becomes serial address
// - Selectable byte order for mapped reads
// - Even prescaler from 2 to 65534
// - Four clock modes from polarity, phase
// - Receive sample delay of zero or one
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module qspi_ctrl #(
  parameter logic [31:0] REG_BASE  = 32'h0000_0000,
  parameter logic [31:0] MMAP_BASE = 32'h1000_0000,
  parameter int          MMAP_AW   = 24
) (
  input  wire logic        CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic [31:0] AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [31:0] ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  output logic             SCLK_OUT,
  output logic             CS_N_OUT,
  output logic [3:0]       IO_OUT,
  output logic [3:0]       IO_OE_N_OUT,
  input  wire logic [3:0]  IO_IN,
  output logic             IRQ_OUT,
  output logic             DMA_RX_REQ_OUT,
  output logic             DMA_TX_REQ_OUT
);
  import qspi_pkg::*;

  typedef struct packed {
    phase_t             ph;
    ctrl_t              ctrl;
    mmcfg_t             mmcfg;
    logic [15:0]        presc;
    logic [31:0]        len;
    logic [7:0]         cmd;
    logic [31:0]        txd;
    logic               tx_full;
    logic [31:0]        rxd;
    logic               rx_full;
    logic [IRQ_W-1:0]   istat;
    logic [IRQ_W-1:0]   imask;
    logic               start_pend;
    logic               mm;
    logic               mm_wr;
    op_t                op;
    logic [14:0]        div;
    logic               sclk_ph;
    logic               first;
    logic [5:0]         beats;
    logic [31:0]        rem;
    logic [2:0]         fbytes;
    logic [2:0]         fmax;
    lane_t              lsh;
    lane_t              dlsh;
    logic               drx;
    logic               drive;
    logic [31:0]        sreg;
    logic [31:0]        rsreg;
    logic [3:0]         io_s1;
    logic [3:0]         io_s2;
    logic [3:0]         io_s3;
    logic               aw_got;
    logic [31:0]        awaddr;
    logic               w_got;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               mmw_pend;
    logic               mmr_pend;
    logic [MMAP_AW-1:0] mm_raddr;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               sclk;
    logic               cs_n;
    logic [3:0]         io_o;
    logic [3:0]         io_oe_n;
    logic               irq;
    logic               dreq_rx;
    logic               dreq_tx;
  } st_t;

  st_t                s_r;
  st_t                s_nxt;
  logic               tick;
  logic               lead;
  logic               samp;
  logic [3:0]         smp;
  logic [IRQ_W-1:0]   ev;
  logic [IRQ_W-1:0]   clr;
  logic [31:0]        wv;
  logic [7:0]         woff;
  logic [7:0]         roff;
  logic [2:0]         fb;
  logic [MMAP_AW-1:0] maddr;
  op_t                nop;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic reg_hit(input logic [31:0] a);
    return (a[31:8] == REG_BASE[31:8]) && (a[7:0] <= OFF_IMASK) && (a[1:0] == 2'h0);
  endfunction : reg_hit

  function automatic logic win_hit(input logic [31:0] a);
    return a[31:MMAP_AW] == MMAP_BASE[31:MMAP_AW];
  endfunction : win_hit

  function automatic logic [31:0] reg_read(input st_t t, input logic [7:0] off);
    case (off)
      OFF_CTRL:   reg_read = {{(32-CTRL_W){1'b0}}, t.ctrl};
      OFF_MMCFG:  reg_read = {{(32-MMCFG_W){1'b0}}, t.mmcfg};
      OFF_PRESC:  reg_read = {16'h0000, t.presc};
      OFF_LEN:    reg_read = t.len;
      OFF_CMD:    reg_read = {24'h000000, t.cmd};
      OFF_TXDATA: reg_read = t.txd;
      OFF_RXDATA: reg_read = t.rxd;
      OFF_STATUS: reg_read = {28'h0000000, t.mm, t.rx_full, t.tx_full,
                              (t.ph != PH_IDLE) || t.start_pend};
      OFF_ISTAT:  reg_read = {{(32-IRQ_W){1'b0}}, t.istat};
      OFF_IMASK:  reg_read = {{(32-IRQ_W){1'b0}}, t.imask};
      default:    reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Bits that leave per lane step, and the lines that carry them
  function automatic logic [31:0] shift_out(input logic [31:0] r, input lane_t l);
    case (l)
      one_lane_mode: shift_out = {r[30:0], 1'b0};
      two_lane_mode: shift_out = {r[29:0], 2'b00};
      default:       shift_out = {r[27:0], 4'h0};
    endcase
  endfunction : shift_out

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    ev    = '0;
    clr   = '0;
    wv    = 32'h0000_0000;
    fb    = 3'h0;
    nop   = op_select(s_r.mmcfg, s_r.mmw_pend);
    woff  = s_r.awaddr[7:0];
    roff  = ARADDR_IN[7:0];
    maddr = s_r.mm_wr ? s_r.awaddr[MMAP_AW-1:0] : s_r.mm_raddr;
    s_nxt.io_s1 = IO_IN;
    s_nxt.io_s2 = s_r.io_s1;
    s_nxt.io_s3 = s_r.io_s2;
    smp  = s_r.ctrl.rx_delay ? s_r.io_s3 : s_r.io_s2;
    tick = (s_r.div == s_r.presc[15:1] - 15'h0001);
    lead = ~s_r.sclk_ph;
    samp = lead ^ s_r.ctrl.cpha;

    // Bus channels
    if (AWVALID_IN && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = AWADDR_IN;
    end
    if (WVALID_IN && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = WDATA_IN;
      s_nxt.wstrb = WSTRB_IN;
    end
    if (s_r.bvalid && BREADY_IN) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && RREADY_IN) begin
      s_nxt.rvalid = 1'b0;
    end

    // Write once both halves are held
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid && !s_r.mmw_pend) begin
      if (win_hit(s_r.awaddr)) begin
        // Flash is read-only through the window; partial words are refused
        if (!s_r.mmcfg.active || !s_r.mmcfg.dev_psram || s_r.wstrb != STRB_ALL) begin
          s_nxt.bvalid = 1'b1;
          s_nxt.bresp  = RESP_SLVERR;
          s_nxt.aw_got = 1'b0;
          s_nxt.w_got  = 1'b0;
        end else begin
          s_nxt.mmw_pend = 1'b1;
        end
      end else begin
        s_nxt.bvalid = 1'b1;
        s_nxt.bresp  = reg_hit(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
        s_nxt.aw_got = 1'b0;
        s_nxt.w_got  = 1'b0;
        wv = merge(reg_read(s_r, woff), s_r.wdata, s_r.wstrb);
        if (reg_hit(s_r.awaddr)) begin
          case (woff)
            OFF_CTRL: begin
              // Configuration is frozen while a frame is on the wire
              if (s_r.ph == PH_IDLE && !s_r.start_pend) begin
                s_nxt.ctrl       = ctrl_t'(wv[CTRL_W-1:0]);
                s_nxt.start_pend = wv[CTRL_START_BIT];
              end
            end
            OFF_MMCFG: begin
              if (s_r.ph == PH_IDLE) begin
                s_nxt.mmcfg = mmcfg_t'(wv[MMCFG_W-1:0]);
              end
            end
            OFF_PRESC:  s_nxt.presc = (wv[15:0] < PRESC_MIN) ? PRESC_MIN : {wv[15:1], 1'b0};
            OFF_LEN:    s_nxt.len = wv;
            OFF_CMD:    s_nxt.cmd = wv[7:0];
            OFF_TXDATA: begin
              if (!s_r.tx_full) begin
                s_nxt.txd     = wv;
                s_nxt.tx_full = 1'b1;
              end
            end
            OFF_ISTAT:  clr = s_r.wdata[IRQ_W-1:0] & {IRQ_W{s_r.wstrb[0]}};
            OFF_IMASK:  s_nxt.imask = wv[IRQ_W-1:0];
            default:    s_nxt.bresp = RESP_OKAY;
          endcase
        end
      end
    end

    // Read address
    if (ARVALID_IN && s_r.arready) begin
      if (win_hit(ARADDR_IN) && s_r.mmcfg.active) begin
        s_nxt.mmr_pend = 1'b1;
        s_nxt.mm_raddr = ARADDR_IN[MMAP_AW-1:0];
      end else begin
        s_nxt.rvalid = 1'b1;
        s_nxt.rdata  = reg_hit(ARADDR_IN) ? reg_read(s_r, roff) : 32'h0000_0000;
        s_nxt.rresp  = reg_hit(ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
        if (reg_hit(ARADDR_IN) && roff == OFF_RXDATA) begin
          s_nxt.rx_full = 1'b0;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial engine
    case (s_r.ph)
      PH_IDLE: begin
        s_nxt.div     = 15'h0000;
        s_nxt.sclk_ph = 1'b0;
        s_nxt.first   = 1'b1;
        if (s_r.mmw_pend || s_r.mmr_pend) begin
          s_nxt.mm    = 1'b1;
          s_nxt.mm_wr = s_r.mmw_pend;
          s_nxt.op    = nop;
          s_nxt.sreg  = {nop.opcode, 24'h000000};
          s_nxt.lsh   = one_lane_mode;
          s_nxt.drive = 1'b1;
          s_nxt.beats = CMD_BITS;
          s_nxt.rem   = {29'h0, MM_BYTES};
          s_nxt.fmax  = MM_BYTES;
          s_nxt.dlsh  = nop.data_l;
          s_nxt.drx   = ~s_r.mmw_pend;
          s_nxt.ph    = PH_CMD;
        end else if (s_r.start_pend) begin
          s_nxt.start_pend = 1'b0;
          s_nxt.mm    = 1'b0;
          s_nxt.rem   = s_r.len;
          s_nxt.fmax  = (s_r.ctrl.fw == frame_width_byte) ? 3'h1 :
                        (s_r.ctrl.fw == frame_width_halfword) ? 3'h2 : MM_BYTES;
          s_nxt.dlsh  = s_r.ctrl.lanes;
          s_nxt.drx   = s_r.ctrl.dir_rx;
          s_nxt.sreg  = {s_r.cmd, 24'h000000};
          s_nxt.lsh   = one_lane_mode;
          s_nxt.drive = 1'b1;
          s_nxt.beats = CMD_BITS;
          s_nxt.ph    = s_r.ctrl.cmd_en ? PH_CMD : (s_r.len != 32'h0) ? PH_FWAIT : PH_CSGAP;
        end
      end
      PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA: begin
        s_nxt.div = tick ? 15'h0000 : s_r.div + 15'h0001;
        if (tick) begin
          s_nxt.sclk_ph = ~s_r.sclk_ph;
          if (lead) begin
            s_nxt.first = 1'b0;
          end
          if (samp) begin
            case (s_r.lsh)
              one_lane_mode: s_nxt.rsreg = {s_r.rsreg[30:0], smp[1]};
              two_lane_mode: s_nxt.rsreg = {s_r.rsreg[29:0], smp[1:0]};
              default:       s_nxt.rsreg = {s_r.rsreg[27:0], smp};
            endcase
          end else if (!(lead && s_r.first)) begin
            s_nxt.sreg = shift_out(s_r.sreg, s_r.lsh);
          end
          if (!lead) begin
            s_nxt.beats = s_r.beats - 6'h01;
            if (s_r.beats == 6'h01) begin
              s_nxt.first = 1'b1;
              case (s_r.ph)
                PH_CMD: begin
                  if (s_r.mm) begin
                    s_nxt.ph    = PH_ADDR;
                    s_nxt.sreg  = {maddr[MMAP_AW-1:2], 2'b00, 8'h00};
                    s_nxt.lsh   = s_r.op.addr_l;
                    s_nxt.beats = ADDR_BITS >> s_r.op.addr_l;
                  end else begin
                    s_nxt.ph = (s_r.rem != 32'h0) ? PH_FWAIT : PH_CSGAP;
                  end
                end
                PH_ADDR: begin
                  s_nxt.ph    = (s_r.op.dummy != 6'h00) ? PH_DUMMY : PH_FWAIT;
                  s_nxt.beats = s_r.op.dummy;
                  s_nxt.drive = 1'b0;
                end
                PH_DUMMY: s_nxt.ph = PH_FWAIT;
                PH_DATA: begin
                  if (s_r.drx && !s_r.mm) begin
                    s_nxt.rxd     = samp ? s_nxt.rsreg : s_r.rsreg;
                    s_nxt.rx_full = 1'b1;
                    ev[IRQ_RXNE]  = 1'b1;
                  end
                  s_nxt.rem = s_r.rem - {29'h0, s_r.fbytes};
                  s_nxt.ph  = (s_r.rem == {29'h0, s_r.fbytes}) ? PH_CSGAP : PH_FWAIT;
                end
                default: s_nxt.ph = PH_CSGAP;
              endcase
            end
          end
        end
      end
      PH_FWAIT: begin
        // Clock parks between frames until a word can move: back-pressure from software or DMA
        s_nxt.div     = 15'h0000;
        s_nxt.sclk_ph = 1'b0;
        s_nxt.drive   = 1'b0;
        if (s_r.mm || (s_r.drx ? !s_r.rx_full : s_r.tx_full)) begin
          fb = (s_r.rem < {29'h0, s_r.fmax}) ? s_r.rem[2:0] : s_r.fmax;
          s_nxt.fbytes = fb;
          s_nxt.beats  = {fb, 3'b000} >> s_r.dlsh;
          s_nxt.lsh    = s_r.dlsh;
          s_nxt.drive  = ~s_r.drx;
          s_nxt.rsreg  = 32'h0000_0000;
          s_nxt.first  = 1'b1;
          s_nxt.sreg   = (s_r.mm ? bswap(s_r.wdata) : s_r.txd) << {3'(MM_BYTES - fb), 3'b000};
          if (!s_r.mm && !s_r.drx) begin
            s_nxt.tx_full = 1'b0;
            ev[IRQ_TXE]   = 1'b1;
          end
          s_nxt.ph = PH_DATA;
        end
      end
      PH_CSGAP: begin
        // Select stays low for one half period after the last clock edge, then rises
        s_nxt.sclk_ph = 1'b0;
        s_nxt.drive   = 1'b0;
        s_nxt.div     = tick ? 15'h0000 : s_r.div + 15'h0001;
        if (tick) begin
          s_nxt.ph = PH_IDLE;
          if (!s_r.mm) begin
            ev[IRQ_DONE] = 1'b1;
          end else if (s_r.mm_wr) begin
            s_nxt.bvalid   = 1'b1;
            s_nxt.bresp    = RESP_OKAY;
            s_nxt.aw_got   = 1'b0;
            s_nxt.w_got    = 1'b0;
            s_nxt.mmw_pend = 1'b0;
          end else begin
            s_nxt.rvalid   = 1'b1;
            s_nxt.rresp    = RESP_OKAY;
            s_nxt.rdata    = s_r.mmcfg.endian_big ? s_r.rsreg : bswap(s_r.rsreg);
            s_nxt.mmr_pend = 1'b0;
          end
          s_nxt.mm = 1'b0;
        end
      end
      default: s_nxt.ph = PH_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////////////
    // Events, requests and pins
    s_nxt.istat   = (s_r.istat & ~clr) | ev;
    s_nxt.irq     = |(s_nxt.istat & s_nxt.imask);
    s_nxt.dreq_rx = s_nxt.rx_full && s_r.ctrl.dma_en;
    s_nxt.dreq_tx = (s_nxt.ph == PH_FWAIT) && !s_nxt.mm && !s_nxt.drx && !s_nxt.tx_full && s_r.ctrl.dma_en;
    s_nxt.awready = ~s_nxt.aw_got;
    s_nxt.wready  = ~s_nxt.w_got;
    s_nxt.arready = ~s_nxt.rvalid & ~s_nxt.mmr_pend;
    s_nxt.sclk    = s_nxt.sclk_ph ^ s_r.ctrl.cpol;
    s_nxt.cs_n    = (s_nxt.ph == PH_IDLE);
    case (s_nxt.lsh)
      one_lane_mode: begin
        s_nxt.io_o    = {3'b000, s_nxt.sreg[31]};
        s_nxt.io_oe_n = 4'he;
      end
      two_lane_mode: begin
        s_nxt.io_o    = {2'b00, s_nxt.sreg[31:30]};
        s_nxt.io_oe_n = 4'hc;
      end
      default: begin
        s_nxt.io_o    = s_nxt.sreg[31:28];
        s_nxt.io_oe_n = 4'h0;
      end
    endcase
    if (!s_nxt.drive || s_nxt.ph == PH_IDLE) begin
      s_nxt.io_oe_n = 4'hf;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      s_r         <= '0;
      s_r.ph      <= PH_IDLE;
      s_r.presc   <= PRESC_RST;
      s_r.first   <= 1'b1;
      s_r.awready <= 1'b1;
      s_r.wready  <= 1'b1;
      s_r.arready <= 1'b1;
      s_r.cs_n    <= 1'b1;
      s_r.io_oe_n <= 4'hf;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign AWREADY_OUT    = s_r.awready;
  assign WREADY_OUT     = s_r.wready;
  assign BVALID_OUT     = s_r.bvalid;
  assign BRESP_OUT      = s_r.bresp;
  assign ARREADY_OUT    = s_r.arready;
  assign RVALID_OUT     = s_r.rvalid;
  assign RDATA_OUT      = s_r.rdata;
  assign RRESP_OUT      = s_r.rresp;
  assign SCLK_OUT       = s_r.sclk;
  assign CS_N_OUT       = s_r.cs_n;
  assign IO_OUT         = s_r.io_o;
  assign IO_OE_N_OUT    = s_r.io_oe_n;
  assign IRQ_OUT        = s_r.irq;
  assign DMA_RX_REQ_OUT = s_r.dreq_rx;
  assign DMA_TX_REQ_OUT = s_r.dreq_tx;

endmodule : qspi_ctrl

// [hdl/qspi_pkg.sv]
package qspi_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets within the register window
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_MMCFG   = 8'h04;
  localparam logic [7:0]  OFF_PRESC   = 8'h08;
  localparam logic [7:0]  OFF_LEN     = 8'h0c;
  localparam logic [7:0]  OFF_CMD     = 8'h10;
  localparam logic [7:0]  OFF_TXDATA  = 8'h14;
  localparam logic [7:0]  OFF_RXDATA  = 8'h18;
  localparam logic [7:0]  OFF_STATUS  = 8'h1c;
  localparam logic [7:0]  OFF_ISTAT   = 8'h20;
  localparam logic [7:0]  OFF_IMASK   = 8'h24;

  localparam int          CTRL_START_BIT = 31;
  localparam int          CTRL_W         = 10;
  localparam int          MMCFG_W        = 6;
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_TXE        = 0;
  localparam int          IRQ_RXNE       = 1;
  localparam int          IRQ_DONE       = 2;
  localparam logic [15:0] PRESC_RST      = 16'h0002;
  localparam logic [15:0] PRESC_MIN      = 16'h0002;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [3:0]  STRB_ALL       = 4'hf;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial framing
  localparam logic [5:0]  CMD_BITS   = 6'h08;
  localparam logic [5:0]  ADDR_BITS  = 6'h18;
  localparam logic [2:0]  MM_BYTES   = 3'h4;
  localparam logic [5:0]  DUMMY_LONG = 6'h08;
  localparam logic [5:0]  DUMMY_IO4  = 6'h06;
  localparam logic [5:0]  DUMMY_IO2  = 6'h04;

  localparam logic [7:0]  nor_dual_output_read       = 8'h3b;
  localparam logic [7:0]  nor_dual_io_read           = 8'hbb;
  localparam logic [7:0]  nor_quad_output_read       = 8'h6b;
  localparam logic [7:0]  nor_quad_io_read           = 8'heb;
  localparam logic [7:0]  pseudo_sram_fast_quad_read = 8'h0b;
  localparam logic [7:0]  pseudo_sram_quad_io_read   = 8'heb;
  localparam logic [7:0]  pseudo_sram_write_a        = 8'h02;
  localparam logic [7:0]  pseudo_sram_quad_write_b   = 8'h38;

  typedef enum logic [1:0] {
    one_lane_mode  = 2'h0,
    two_lane_mode  = 2'h1,
    four_lane_mode = 2'h2
  } lane_t;

  typedef enum logic [1:0] {
    frame_width_byte     = 2'h0,
    frame_width_halfword = 2'h1,
    frame_width_word     = 2'h2
  } frame_t;

  typedef enum logic [6:0] {
    PH_IDLE  = 7'h01,
    PH_CMD   = 7'h02,
    PH_ADDR  = 7'h04,
    PH_DUMMY = 7'h08,
    PH_FWAIT = 7'h10,
    PH_DATA  = 7'h20,
    PH_CSGAP = 7'h40
  } phase_t;

  typedef struct packed {
    logic   dma_en;
    logic   rx_delay;
    logic   cpha;
    logic   cpol;
    logic   dir_rx;
    logic   cmd_en;
    frame_t fw;
    lane_t  lanes;
  } ctrl_t;

  typedef struct packed {
    logic       endian_big;
    logic       psram_wr_b;
    logic [1:0] rd_sel;
    logic       dev_psram;
    logic       active;
  } mmcfg_t;

  typedef struct packed {
    logic [7:0] opcode;
    lane_t      addr_l;
    lane_t      data_l;
    logic [5:0] dummy;
  } op_t;

  function automatic op_t op_select(input mmcfg_t m, input logic wr);
    op_t o;
    o = '{opcode: pseudo_sram_write_a, addr_l: one_lane_mode, data_l: four_lane_mode, dummy: 6'h00};
    if (wr) begin
      o.opcode = m.psram_wr_b ? pseudo_sram_quad_write_b : pseudo_sram_write_a;
      o.addr_l = m.psram_wr_b ? four_lane_mode : one_lane_mode;
    end else if (m.dev_psram) begin
      o.opcode = m.rd_sel[0] ? pseudo_sram_quad_io_read : pseudo_sram_fast_quad_read;
      o.addr_l = m.rd_sel[0] ? four_lane_mode : one_lane_mode;
      o.dummy  = m.rd_sel[0] ? DUMMY_IO4 : DUMMY_LONG;
    end else begin
      case (m.rd_sel)
        2'h0:    o = '{nor_dual_output_read, one_lane_mode, two_lane_mode, DUMMY_LONG};
        2'h1:    o = '{nor_dual_io_read, two_lane_mode, two_lane_mode, DUMMY_IO2};
        2'h2:    o = '{nor_quad_output_read, one_lane_mode, four_lane_mode, DUMMY_LONG};
        default: o = '{nor_quad_io_read, four_lane_mode, four_lane_mode, DUMMY_IO4};
      endcase
    end
    return o;
  endfunction : op_select

  function automatic logic [31:0] bswap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : bswap

endpackage : qspi_pkg

// [tb/qspi_ctrl_properties.sv]
`timescale 1ns/1ps
module qspi_ctrl_checker (
  input wire logic        CLK_IN,
  input wire logic        RSTN_IN,
  input wire logic        AWVALID_IN,
  input wire logic        AWREADY_OUT,
  input wire logic        BVALID_OUT,
  input wire logic        BREADY_IN,
  input wire logic [31:0] ARADDR_IN,
  input wire logic        ARVALID_IN,
  input wire logic        ARREADY_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic [1:0]  RRESP_OUT,
  input wire logic        RVALID_OUT,
  input wire logic        RREADY_IN,
  input wire logic        CS_N_OUT,
  input wire logic [3:0]  IO_OE_N_OUT
);
  import qspi_pkg::*;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence s_reg_read;
    ARVALID_IN && ARREADY_OUT && ARADDR_IN[31:28] == 4'h0;
  endsequence
  sequence s_rd_done;
    RVALID_OUT && RREADY_IN;
  endsequence
  a_bresp_hold: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT) else $error("bvalid dropped");
  a_rdata_hold: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT)) else $error("rdata moved");
  a_aw_blocked: assert property (AWVALID_IN && AWREADY_OUT |=> !AWREADY_OUT) else $error("aw open");
  a_ar_blocked: assert property (RVALID_OUT |-> !ARREADY_OUT) else $error("ar open");
  a_reg_read: assert property (s_reg_read |=> RVALID_OUT) else $error("read late");
  a_rd_release: assert property (s_rd_done |=> !RVALID_OUT && ARREADY_OUT) else $error("read stuck");
  a_err_zero: assert property (RVALID_OUT && RRESP_OUT == RESP_SLVERR |-> RDATA_OUT == 32'h0) else $error("err data");
  a_lines_idle: assert property (CS_N_OUT [*3] |-> IO_OE_N_OUT == 4'hf) else $error("lines driven");
endmodule : qspi_ctrl_checker
bind qspi_ctrl qspi_ctrl_checker u_qspi_ctrl_checker (.*);

// [tb/qspi_mem_model.sv]
`timescale 1ns/1ps
module qspi_mem_model (
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [7:0]  op_out,
  output logic      [23:0] adr_out
);
  logic [7:0] beat = 8'h00;
  // Reply is the beat number, so any lane mix gives a predictable word
  initial io_out = 4'h0;
  initial op_out = 8'h00;
  initial adr_out = 24'h0;
  // Count clears on deselect so beat zero is on the lines as select falls
  always @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      beat <= 8'h00;
    end else begin
      if (beat < 8'h08) op_out <= {op_out[6:0], io_in[0]};
      else if (beat < 8'h20) adr_out <= {adr_out[22:0], io_in[0]};
      beat <= beat + 8'h01;
    end
  end
  // Released lines flip so a stale value is never mistaken for data
  always @(negedge sclk_in or posedge cs_n_in or negedge cs_n_in) io_out <= cs_n_in ? ~io_out : beat[3:0];
endmodule : qspi_mem_model

// [tb/test_quad_spi_memory_controller.sv]
`timescale 1ns/1ps
module test_quad_spi_memory_controller;
  import qspi_pkg::*;
  logic        CLK_IN = 1'b0, RSTN_IN = 1'b0, AWVALID_IN = 1'b0, WVALID_IN = 1'b0;
  logic        BREADY_IN = 1'b0, ARVALID_IN = 1'b0, RREADY_IN = 1'b0;
  logic        AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT, SCLK_OUT, CS_N_OUT;
  logic        IRQ_OUT, DMA_RX_REQ_OUT, DMA_TX_REQ_OUT;
  logic [31:0] AWADDR_IN = '0, WDATA_IN = '0, ARADDR_IN = '0, RDATA_OUT, rdat;
  logic [3:0]  WSTRB_IN = STRB_ALL, IO_OUT, IO_OE_N_OUT, IO_IN, mdl_io;
  logic [1:0]  BRESP_OUT, RRESP_OUT, rsp;
  logic [7:0]  op;
  logic [23:0] adr;
  int          fail_count = 0, checks = 0, cyc = 0;
  logic [31:0] rx [3] = '{32'h3333, 32'h1b1b, 32'h89ab};
  logic [7:0]  mm [10] = '{8'h01, 8'h05, 8'h09, 8'h0d, 8'h29, 8'h03, 8'h07, 8'h03, 8'h13, 8'h01};
  logic [7:0]  mo [10] = '{8'h3b, 8'hbb, 8'h6b, 8'heb, 8'h6b, 8'h0b, 8'heb, 8'h02, 8'h38, 8'h38};
  logic [31:0] mx [10] = '{32'h1b1b1b1b, 32'h1b1b1b1b, 32'hefcdab89, 32'hab896745, 32'h89abcdef,
                           32'hefcdab89, 32'hab896745, 32'h0, 32'h0, 32'h2};
  assign IO_IN = (IO_OE_N_OUT & mdl_io) | (~IO_OE_N_OUT & IO_OUT);
  qspi_ctrl u_qspi_ctrl (.*);
  qspi_mem_model u_qspi_mem_model (.sclk_in(SCLK_OUT), .cs_n_in(CS_N_OUT), .io_in(IO_IN), .io_out(mdl_io),
                                   .op_out(op), .adr_out(adr));
  always #5 CLK_IN = ~CLK_IN;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    AWADDR_IN <= a;
    WDATA_IN <= d;
    AWVALID_IN <= 1'b1;
    WVALID_IN <= 1'b1;
    BREADY_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      if (AWREADY_OUT) AWVALID_IN <= 1'b0;
      if (WREADY_OUT) WVALID_IN <= 1'b0;
    end while (!BVALID_OUT);
    rsp = BRESP_OUT;
    BREADY_IN <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge CLK_IN);
    ARADDR_IN <= a;
    ARVALID_IN <= 1'b1;
    RREADY_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      if (ARREADY_OUT) ARVALID_IN <= 1'b0;
    end while (!RVALID_OUT);
    rdat = RDATA_OUT;
    rsp = RRESP_OUT;
    RREADY_IN <= 1'b0;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  // Ceiling sits well above the longest mapped sequence so a slow but legal design passes
  always @(posedge CLK_IN) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge CLK_IN);
    RSTN_IN <= 1'b1;
    rd(OFF_PRESC);
    chk("presc", rdat, 32'h2);
    wr(OFF_PRESC, 32'h7);
    rd(OFF_PRESC);
    chk("presc", rdat, 32'h6);
    rd(32'h40);
    chk("unmapped", {rdat[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr(OFF_PRESC, 32'h8);
    wr(OFF_LEN, 32'h2);
    wr(OFF_IMASK, 32'h4);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CTRL, 32'h8000_0224 | i | (i == 2 ? 32'h10 : 32'h0) | (i == 1 ? 32'h100 : 32'h0));
      do rd(OFF_STATUS); while (rdat[0]);
      chk("irq dma", {IRQ_OUT, DMA_RX_REQ_OUT}, 32'h3);
      rd(OFF_RXDATA);
      chk("rxdata", rdat, rx[i]);
      wr(OFF_ISTAT, 32'h7);
      rd(OFF_ISTAT);
      chk("istat", {rdat[29:0], IRQ_OUT, DMA_RX_REQ_OUT}, 32'h0);
    end
    wr(OFF_TXDATA, 32'h5a);
    wr(OFF_CTRL, 32'h8000_0200);
    repeat (100) @(posedge CLK_IN);
    chk("dma tx", {31'h0, DMA_TX_REQ_OUT}, 32'h1);
    wr(OFF_TXDATA, 32'h3c);
    do rd(OFF_STATUS); while (rdat[0]);
    chk("tx byte", {24'h0, op}, 32'h5a);
    rd(OFF_ISTAT);
    chk("istat tx", {rdat[30:0], IRQ_OUT}, 32'hb);
    for (int i = 0; i < 10; i++) begin
      wr(OFF_MMCFG, {24'h0, mm[i]});
      if (i < 7) rd(32'h1000_0010);
      else wr(32'h1000_0010, 32'h1234_5678);
      chk("mmap", i < 7 ? rdat : {30'h0, rsp}, mx[i]);
      chk("opcode", {24'h0, op}, {24'h0, mo[i]});
      if (!mm[i][2] && !mm[i][4] && i < 9) chk("addr", {8'h0, adr}, 32'h10);
    end
    wr(OFF_MMCFG, 32'h0);
    rd(32'h1000_0010);
    chk("inactive", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    complete_run();
  end
endmodule : test_quad_spi_memory_controller
